// ===== inc/fbr_pkg.sv
// Constants and types for the frame buffer read master
package fbr_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int FBR_ADDR_W     = 32;
    localparam int FBR_DATA_W     = 64;
    localparam int FBR_ID_W       = 4;
    localparam int FBR_LEN_W      = 4;
    localparam int FBR_FIFO_DEPTH = 32;
    localparam int FBR_MAX_OUTST  = 16;
    localparam int FBR_FRAME_W    = 24;

    // ------------------------------------------------------------
    // Read address channel encodings
    // ------------------------------------------------------------
    localparam logic [2:0] FBR_SIZE_8B    = 3'h3;
    localparam logic [1:0] FBR_BURST_INCR = 2'h1;
    localparam logic       FBR_LOCK_OFF   = 1'h0;
    localparam logic [3:0] FBR_CACHE_OFF  = 4'h0;
    localparam logic [2:0] FBR_PROT_OFF   = 3'h0;
    localparam int         FBR_RESP_ERR_BIT = 1;

    // Beat counts of the legal burst lengths
    localparam logic [4:0] FBR_BEATS_1  = 5'h01;
    localparam logic [4:0] FBR_BEATS_4  = 5'h04;
    localparam logic [4:0] FBR_BEATS_8  = 5'h08;
    localparam logic [4:0] FBR_BEATS_16 = 5'h10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBR_BL_1  = 2'h0,
        FBR_BL_4  = 2'h1,
        FBR_BL_8  = 2'h2,
        FBR_BL_16 = 2'h3
    } fbr_blen_t;

    typedef enum logic [1:0] {
        FBR_ST_IDLE = 2'h0,
        FBR_ST_GAP  = 2'h1,
        FBR_ST_ADDR = 2'h2
    } fbr_state_t;

endpackage

// ===== inc/fbr_fifo_if.sv
// Link between the read master and its input FIFO
`timescale 1ns/1ps

interface fbr_fifo_if #(
    parameter int DATA_W = 64,
    parameter int LVL_W  = 6
);
    logic              wr_valid;
    logic [DATA_W-1:0] wr_data;
    logic              pop;
    logic [DATA_W-1:0] rd_data;
    logic              rd_valid;
    logic [LVL_W-1:0]  level;

    modport writer (output wr_valid, wr_data, pop, input rd_data, rd_valid, level);
    modport store  (input wr_valid, wr_data, pop, output rd_data, rd_valid, level);
endinterface

// ===== hdl/fbr_input_fifo.sv
// Input FIFO with registered show-ahead output
`timescale 1ns/1ps

module fbr_input_fifo #(
    parameter int DATA_W = 64,
    parameter int DEPTH  = 32,
    parameter int LVL_W  = 6
) (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic sys_rst_n,
    input wire logic clk_en,
    // Store side
    fbr_fifo_if.store fi
);
    localparam int PW = $clog2(DEPTH);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0]     wptr_reg;
    logic [PW-1:0]     rptr_reg;
    logic [LVL_W-1:0]  arr_cnt_reg;
    logic [LVL_W-1:0]  level_reg;
    logic [DATA_W-1:0] dout_reg;
    logic              dvalid_reg;
    logic              pop_ok;
    logic              load;

    // Pop only a shown word; refill the output stage when it frees
    assign pop_ok = fi.pop & dvalid_reg;
    assign load   = (arr_cnt_reg != '0) & (~dvalid_reg | pop_ok);

    // Storage array, written on the bus clock
    always_ff @(posedge clk) begin
        if (clk_en && fi.wr_valid) begin
            mem[wptr_reg] <= fi.wr_data;
        end
    end

    // Pointers and array occupancy
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            wptr_reg    <= '0;
            rptr_reg    <= '0;
            arr_cnt_reg <= '0;
        end else if (clk_en) begin
            wptr_reg    <= wptr_reg + PW'(fi.wr_valid);
            rptr_reg    <= rptr_reg + PW'(load);
            arr_cnt_reg <= arr_cnt_reg + LVL_W'(fi.wr_valid) - LVL_W'(load);
        end
    end

    // Output stage and total fill level
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            dout_reg   <= '0;
            dvalid_reg <= 1'b0;
            level_reg  <= '0;
        end else if (clk_en) begin
            if (load) begin
                dout_reg   <= mem[rptr_reg];
                dvalid_reg <= 1'b1;
            end else if (pop_ok) begin
                dvalid_reg <= 1'b0;
            end
            level_reg <= level_reg + LVL_W'(fi.wr_valid) - LVL_W'(pop_ok);
        end
    end

    assign fi.rd_data  = dout_reg;
    assign fi.rd_valid = dvalid_reg;
    assign fi.level    = level_reg;

    a_level_step: assert property (@(posedge clk) disable iff (!sys_rst_n)
        clk_en && fi.wr_valid && !pop_ok |=> level_reg == $past(level_reg) + LVL_W'(1))
        else $error("fifo level did not count a write");

    a_level_bound: assert property (@(posedge clk) disable iff (!sys_rst_n)
        level_reg <= LVL_W'(DEPTH))
        else $error("fifo level above depth");

endmodule // fbr_input_fifo

// ===== hdl/fbr_read_master.sv
// Frame buffer read master: issues read bursts and fills the input FIFO
`timescale 1ns/1ps

// Behaviour
// - Active-low reset clears master and core.
// - All state changes on bus clock rise.
// - Bus clock is one pixel clock source.
// - Drive 32-bit address and 4-bit id.
// - Bursts of 1, 4, 8, 16 only.
// - Every beat is eight bytes wide.
// - Only incrementing bursts are requested.
// - Lock, cache, protection attributes unused.
// - Address valid only with valid fields.
// - Read ready held high; FIFO space reserved at issue.
// - At most sixteen bursts outstanding.
// - Data lands in 32 by 64 FIFO.
module fbr_read_master
    import fbr_pkg::*;
#(
    parameter int ADDR_W    = FBR_ADDR_W,
    parameter int DATA_W    = FBR_DATA_W,
    parameter int ID_W      = FBR_ID_W,
    parameter int DEPTH     = FBR_FIFO_DEPTH,
    parameter int MAX_OUTST = FBR_MAX_OUTST,
    parameter int FRAME_W   = FBR_FRAME_W
) (
    // Clock, reset and freeze
    input  wire logic               clk,
    input  wire logic               sys_rst_n,
    input  wire logic               clk_en,
    // Frame control
    input  wire logic               frame_start,
    input  wire logic [ADDR_W-1:0]  frame_base,
    input  wire logic [FRAME_W-1:0] frame_beats,
    input  wire logic [1:0]         burst_sel,
    output logic                    busy,
    output logic                    frame_done,
    output logic                    resp_err,
    // Pixel clock source choice
    input  wire logic               pix_alt_sel,
    input  wire logic               pix_alt_clk,
    output logic                    pix_tick,
    // Read address channel
    output logic [ID_W-1:0]         arid,
    output logic [ADDR_W-1:0]       araddr,
    output logic [FBR_LEN_W-1:0]    arlen,
    output logic [2:0]              arsize,
    output logic [1:0]              arburst,
    output logic                    read_lock_attribute,
    output logic [3:0]              arcache,
    output logic [2:0]              arprot,
    output logic                    arvalid,
    input  wire logic               arready,
    // Read data channel
    input  wire logic [ID_W-1:0]    rid,
    input  wire logic [DATA_W-1:0]  rdata,
    input  wire logic [1:0]         rresp,
    input  wire logic               rlast,
    input  wire logic               rvalid,
    output logic                    rready,
    // FIFO drain side
    input  wire logic               fifo_pop,
    output logic [DATA_W-1:0]       fifo_data,
    output logic                    fifo_valid,
    output logic [$clog2(DEPTH+1)-1:0] fifo_level
);
    localparam int LVL_W = $clog2(DEPTH + 1);
    localparam int RW    = LVL_W + 1;
    localparam int OW    = $clog2(MAX_OUTST + 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fbr_state_t          state_reg;
    fbr_blen_t           blen_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [FRAME_W-1:0]  left_reg;
    logic [ID_W-1:0]     id_reg;
    logic [OW-1:0]       outst_reg;
    logic [LVL_W-1:0]    inflight_reg;
    logic [ID_W-1:0]     arid_reg;
    logic [ADDR_W-1:0]   araddr_reg;
    logic [FBR_LEN_W-1:0] arlen_reg;
    logic [2:0]          arsize_reg;
    logic [1:0]          arburst_reg;
    logic                lock_reg;
    logic [3:0]          arcache_reg;
    logic [2:0]          arprot_reg;
    logic                arvalid_reg;
    logic                rready_reg;
    logic                busy_reg;
    logic                done_reg;
    logic                err_reg;
    logic                pix_s1_reg;
    logic                pix_s2_reg;
    logic                pix_s3_reg;
    logic                pix_tick_reg;
    logic [4:0]          beats_now;
    logic [4:0]          pend_beats;
    logic [RW-1:0]       resv;
    logic                room_ok;
    logic                can_issue;
    logic                ar_fire;
    logic                r_fire;
    logic                r_end;
    logic                all_done;

    fbr_fifo_if #(.DATA_W(DATA_W), .LVL_W(LVL_W)) fi ();

    // ------------------------------------------------------------
    // Burst length choice
    // ------------------------------------------------------------
    // Largest legal burst not above the chosen length or the remainder
    function automatic logic [4:0] fbr_pick_beats(input fbr_blen_t sel,
                                                  input logic [FRAME_W-1:0] left);
        logic [4:0] want;
        logic [4:0] cap;
        case (sel)
            FBR_BL_4:  want = FBR_BEATS_4;
            FBR_BL_8:  want = FBR_BEATS_8;
            FBR_BL_16: want = FBR_BEATS_16;
            default:   want = FBR_BEATS_1;
        endcase
        cap = (|left[FRAME_W-1:4]) ? FBR_BEATS_16 : left[4:0];
        if (cap > want) begin
            cap = want;
        end
        if (cap >= FBR_BEATS_16) begin
            return FBR_BEATS_16;
        end else if (cap >= FBR_BEATS_8) begin
            return FBR_BEATS_8;
        end else if (cap >= FBR_BEATS_4) begin
            return FBR_BEATS_4;
        end
        return FBR_BEATS_1;
    endfunction

    // ------------------------------------------------------------
    // Issue and handshake terms
    // ------------------------------------------------------------
    assign beats_now  = fbr_pick_beats(blen_reg, left_reg);
    assign pend_beats = 5'({1'b0, arlen_reg}) + 5'h01;
    // Reserved slots: words held plus beats still on their way
    assign resv       = RW'(fi.level) + RW'(inflight_reg);
    assign room_ok    = (resv + RW'(beats_now)) <= RW'(DEPTH);
    assign can_issue  = (state_reg == FBR_ST_GAP) && (left_reg != '0) && room_ok
                        && (outst_reg < OW'(MAX_OUTST));
    assign ar_fire    = arvalid_reg & arready;
    assign r_fire     = rvalid & rready_reg;
    assign r_end      = r_fire & rlast;
    assign all_done   = (left_reg == '0) && (inflight_reg == '0) && (outst_reg == '0);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Idle, wait for room, present one address
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            state_reg <= FBR_ST_IDLE;
        end else if (clk_en) begin
            case (state_reg)
                FBR_ST_IDLE: begin
                    if (frame_start) begin
                        state_reg <= FBR_ST_GAP;
                    end
                end
                FBR_ST_GAP: begin
                    if (all_done) begin
                        state_reg <= FBR_ST_IDLE;
                    end else if (can_issue) begin
                        state_reg <= FBR_ST_ADDR;
                    end
                end
                FBR_ST_ADDR: begin
                    if (arready) begin
                        state_reg <= FBR_ST_GAP;
                    end
                end
                default: state_reg <= FBR_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame walk
    // ------------------------------------------------------------
    // Next address, beats left and id advance on each accepted address
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            addr_reg <= '0;
            left_reg <= '0;
            blen_reg <= FBR_BL_1;
            id_reg   <= '0;
        end else if (clk_en) begin
            if (state_reg == FBR_ST_IDLE && frame_start) begin
                addr_reg <= frame_base;
                left_reg <= frame_beats;
                blen_reg <= fbr_blen_t'(burst_sel);
            end else if (ar_fire) begin
                addr_reg <= addr_reg + ADDR_W'({pend_beats, 3'h0});
                left_reg <= left_reg - FRAME_W'(pend_beats);
                id_reg   <= id_reg + ID_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Read address channel
    // ------------------------------------------------------------
    // Load fields with valid, hold all until the slave takes them
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            arvalid_reg <= 1'b0;
            arid_reg    <= '0;
            araddr_reg  <= '0;
            arlen_reg   <= '0;
            arsize_reg  <= FBR_SIZE_8B;
            arburst_reg <= FBR_BURST_INCR;
        end else if (clk_en) begin
            if (can_issue) begin
                arvalid_reg <= 1'b1;
                arid_reg    <= id_reg;
                araddr_reg  <= addr_reg;
                arlen_reg   <= FBR_LEN_W'(beats_now - 5'h01);
                arsize_reg  <= FBR_SIZE_8B;
                arburst_reg <= FBR_BURST_INCR;
            end else if (ar_fire) begin
                arvalid_reg <= 1'b0;
            end
        end
    end

    // Unused attributes sit at zero for good
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            lock_reg    <= FBR_LOCK_OFF;
            arcache_reg <= FBR_CACHE_OFF;
            arprot_reg  <= FBR_PROT_OFF;
        end else if (clk_en) begin
            lock_reg    <= FBR_LOCK_OFF;
            arcache_reg <= FBR_CACHE_OFF;
            arprot_reg  <= FBR_PROT_OFF;
        end
    end

    // ------------------------------------------------------------
    // Outstanding bookkeeping
    // ------------------------------------------------------------
    // Bursts open and beats still owed by the slave
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            outst_reg    <= '0;
            inflight_reg <= '0;
        end else if (clk_en) begin
            outst_reg    <= outst_reg + OW'(ar_fire) - OW'(r_end);
            inflight_reg <= inflight_reg + (ar_fire ? LVL_W'(pend_beats) : '0)
                            - LVL_W'(r_fire);
        end
    end

    // ------------------------------------------------------------
    // Read data channel
    // ------------------------------------------------------------
    // Space is reserved before issue, so every returned beat has a slot
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            rready_reg <= 1'b0;
        end else if (clk_en) begin
            rready_reg <= 1'b1;
        end
    end

    // Beats go straight into the FIFO
    assign fi.wr_valid = r_fire;
    assign fi.wr_data  = rdata;
    assign fi.pop      = fifo_pop;

    fbr_input_fifo #(
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH),
        .LVL_W  (LVL_W)
    ) u_input_fifo (
        .clk       (clk),
        .sys_rst_n (sys_rst_n),
        .clk_en    (clk_en),
        .fi        (fi.store)
    );

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // Busy level, done pulse, sticky error (error wins over clear)
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg  <= 1'b0;
        end else if (clk_en) begin
            busy_reg <= (state_reg != FBR_ST_IDLE);
            done_reg <= (state_reg == FBR_ST_GAP) && all_done;
            if (r_fire && rresp[FBR_RESP_ERR_BIT]) begin
                err_reg <= 1'b1;
            end else if (state_reg == FBR_ST_IDLE && frame_start) begin
                err_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pixel clock source
    // ------------------------------------------------------------
    // Bus clock ticks every cycle; alternate source synchronised first
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            pix_s1_reg   <= 1'b0;
            pix_s2_reg   <= 1'b0;
            pix_s3_reg   <= 1'b0;
            pix_tick_reg <= 1'b0;
        end else if (clk_en) begin
            pix_s1_reg   <= pix_alt_clk;
            pix_s2_reg   <= pix_s1_reg;
            pix_s3_reg   <= pix_s2_reg;
            pix_tick_reg <= pix_alt_sel ? (pix_s2_reg & ~pix_s3_reg) : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy                = busy_reg;
    assign frame_done          = done_reg;
    assign resp_err            = err_reg;
    assign pix_tick            = pix_tick_reg;
    assign arid                = arid_reg;
    assign araddr              = araddr_reg;
    assign arlen               = arlen_reg;
    assign arsize              = arsize_reg;
    assign arburst             = arburst_reg;
    assign read_lock_attribute = lock_reg;
    assign arcache             = arcache_reg;
    assign arprot              = arprot_reg;
    assign arvalid             = arvalid_reg;
    assign rready              = rready_reg;
    assign fifo_data           = fi.rd_data;
    assign fifo_valid          = fi.rd_valid;
    assign fifo_level          = fi.level;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_quiet: assert property (@(posedge clk) disable iff (!sys_rst_n)
        !$past(sys_rst_n) |-> !arvalid_reg && outst_reg == '0)
        else $error("request state not clear after reset");

    a_ar_hold: assert property (@(posedge clk) disable iff (!sys_rst_n)
        arvalid_reg && !arready |=> arvalid_reg && $stable(araddr_reg)
        && $stable(arlen_reg) && $stable(arid_reg))
        else $error("address dropped or changed before ready");

    a_len_legal: assert property (@(posedge clk) disable iff (!sys_rst_n)
        arvalid_reg |-> arlen_reg inside {4'h0, 4'h3, 4'h7, 4'hf})
        else $error("illegal burst length");

    a_size_burst: assert property (@(posedge clk) disable iff (!sys_rst_n)
        arvalid_reg |-> arsize_reg == 3'h3 && arburst_reg == 2'h1)
        else $error("size or burst type wrong");

    a_attr_zero: assert property (@(posedge clk) disable iff (!sys_rst_n)
        !lock_reg && arcache_reg == 4'h0 && arprot_reg == 3'h0)
        else $error("unused attributes not zero");

    a_outst_max: assert property (@(posedge clk) disable iff (!sys_rst_n)
        outst_reg <= OW'(MAX_OUTST))
        else $error("too many bursts outstanding");

    a_room_kept: assert property (@(posedge clk) disable iff (!sys_rst_n)
        ar_fire |=> resv <= RW'(DEPTH))
        else $error("burst issued without room");

    a_rready_room: assert property (@(posedge clk) disable iff (!sys_rst_n)
        r_fire |-> fi.level < LVL_W'(DEPTH) && inflight_reg != '0)
        else $error("beat taken with no slot");

    a_addr_step: assert property (@(posedge clk) disable iff (!sys_rst_n)
        ar_fire && clk_en |=> addr_reg == $past(araddr_reg) + (ADDR_W'($past(arlen_reg)) + ADDR_W'(1)) * ADDR_W'(8))
        else $error("next address not one burst further");

endmodule // fbr_read_master

// ===== dv/fbr_mem_model.sv
// Behavioural memory slave that answers read bursts
`timescale 1ns/1ps

module fbr_mem_model (
    // Clock, reset, pacing and error injection
    input  wire logic        clk,
    input  wire logic        sys_rst_n,
    input  wire logic        slow,
    input  wire logic        err,
    // Read address channel
    input  wire logic [3:0]  arid,
    input  wire logic [31:0] araddr,
    input  wire logic [3:0]  arlen,
    input  wire logic        arvalid,
    output logic             arready,
    // Read data channel
    output logic [3:0]       rid,
    output logic [63:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rlast,
    output logic             rvalid,
    input  wire logic        rready
);
    logic [39:0] q[$];
    logic [3:0]  beat;
    logic        tog;
    logic [31:0] a;

    // Accept addresses, return beats in order; idle data is scrambled
    always @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            q.delete();
            {arready, rvalid, rlast, tog, beat, rid, rresp} <= '0;
            rdata <= 64'h0;
        end else begin
            tog     <= ~tog;
            arready <= !slow || tog;
            if (arvalid && arready) q.push_back({arid, arlen, araddr});
            if (!rvalid || rready) begin
                if (q.size() > 0 && (!slow || tog)) begin
                    a = q[0][31:0] + {beat, 3'h0};
                    rdata  <= {~a, a};
                    rresp  <= (err && beat == 4'h0) ? 2'h2 : 2'h0;
                    rlast  <= (beat == q[0][35:32]);
                    rid    <= q[0][39:36];
                    rvalid <= 1'b1;
                    if (beat == q[0][35:32]) begin
                        void'(q.pop_front());
                        beat <= 4'h0;
                    end else beat <= beat + 4'h1;
                end else begin
                    rvalid <= 1'b0;
                    rdata  <= ~rdata;
                end
            end
        end
    end
endmodule // fbr_mem_model

// ===== dv/tb.sv
// Self-checking bench for the frame buffer read master
`timescale 1ns/1ps

module tb;
    import fbr_pkg::*;
    logic clk = 0, sys_rst_n = 0, slow = 0, err = 0, frame_start = 0, fifo_pop = 1, pix_alt_sel = 0, pix_alt_clk = 0;
    logic [31:0] frame_base = 32'h0, nxt, ea, nxt_w;
    logic [23:0] frame_beats = 24'h0;
    logic [1:0] burst_sel = 2'h0, rresp;
    logic [3:0] arid, rid, arlen, nid, arcache;
    logic [2:0] arsize, arprot;
    logic [1:0] arburst;
    logic [63:0] rdata, fifo_data;
    logic [5:0] fifo_level;
    logic busy, frame_done, resp_err, pix_tick, lock, arvalid, arready, rlast, rvalid, rready, fifo_valid, have_id;
    int miscompares = 0, total_checks = 0, cycles = 0, left, sel_n, i;
    logic [32:0] rows[4] = '{{2'h3, 24'd37, 1'b0, 1'b0, 1'b0, 4'h0}, {2'h2, 24'd13, 1'b1, 1'b0, 1'b0, 4'h0},
                              {2'h1, 24'd6, 1'b0, 1'b1, 1'b1, 4'h0}, {2'h0, 24'd2, 1'b1, 1'b0, 1'b0, 4'h0}};

    fbr_read_master i_fbr_read_master (.clk(clk), .sys_rst_n(sys_rst_n), .clk_en(1'b1),
        .frame_start(frame_start), .frame_base(frame_base), .frame_beats(frame_beats), .burst_sel(burst_sel),
        .busy(busy), .frame_done(frame_done), .resp_err(resp_err), .pix_alt_sel(pix_alt_sel),
        .pix_alt_clk(pix_alt_clk),
        .pix_tick(pix_tick), .arid(arid), .araddr(nxt_w), .arlen(arlen), .arsize(arsize), .arburst(arburst),
        .read_lock_attribute(lock), .arcache(arcache), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rid(rid), .rdata(rdata), .rresp(rresp), .rlast(rlast), .rvalid(rvalid), .rready(rready),
        .fifo_pop(fifo_pop), .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_level(fifo_level));
    fbr_mem_model i_fbr_mem_model (.clk(clk), .sys_rst_n(sys_rst_n), .slow(slow), .err(err), .arid(arid),
        .araddr(nxt_w), .arlen(arlen), .arvalid(arvalid), .arready(arready), .rid(rid), .rdata(rdata),
        .rresp(rresp), .rlast(rlast), .rvalid(rvalid), .rready(rready));

    always #20 clk = ~clk;

    task check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Expected burst: largest legal length within preference and what is left
    function automatic int blen(input int s, input int l);
        int m;
        m = (s > l) ? l : s;
        return (m >= 16) ? 16 : (m >= 8) ? 8 : (m >= 4) ? 4 : 1;
    endfunction

    // Address channel and FIFO output monitor; cycle ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            stop_test();
        end
        if (sys_rst_n && arvalid && arready) begin
            check(arlen, blen(sel_n, left) - 1);
            check(nxt_w, nxt);
            if (have_id) check(arid, nid);
            check({arsize, arburst}, {FBR_SIZE_8B, FBR_BURST_INCR});
            check({lock, arcache, arprot}, 8'h0);
            nxt = nxt + blen(sel_n, left) * 8;
            left = left - blen(sel_n, left);
            nid = arid + 4'h1;
            have_id = 1'b1;
        end
        if (sys_rst_n && fifo_valid && fifo_pop) begin
            check(fifo_data, {~ea, ea});
            ea = ea + 32'h8;
        end
    end

    task run(input logic [32:0] r);
        @(negedge clk);
        {burst_sel, frame_beats, slow, err} = r[32:5];
        sel_n = (burst_sel == 2'h0) ? 1 : (burst_sel == 2'h1) ? 4 : (burst_sel == 2'h2) ? 8 : 16;
        frame_base = 32'h1000_0000 + (frame_beats << 8);
        {nxt, ea, left} = {frame_base, frame_base, 32'(frame_beats)};
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
        @(negedge clk);
        check(busy, 1'b1);
        for (int k = 0; k < 3000 && frame_done !== 1'b1; k++) @(negedge clk);
        check(frame_done, 1'b1);
        check(left, 0);
        repeat (6) @(negedge clk);
        check({fifo_level, busy, resp_err}, {6'h0, 1'b0, r[4]});
    endtask

    initial begin
        repeat (12) @(negedge clk);
        check({arvalid, rready, busy, arsize, arburst}, {3'h0, 3'h3, 2'h1});
        sys_rst_n = 1'b1;
        have_id = 1'b0;
        @(negedge clk);
        check({rready, pix_tick}, 2'h3);
        for (i = 0; i < 4; i++) run(rows[i]);
        // Alternate pixel source: one tick per synchronised rising edge
        {pix_alt_sel, pix_alt_clk} = 2'h2;
        repeat (4) @(negedge clk);
        check(pix_tick, 1'b0);
        pix_alt_clk = 1'b1;
        repeat (3) @(negedge clk);
        check(pix_tick, 1'b1);
        @(negedge clk);
        check(pix_tick, 1'b0);
        // Reset in mid-frame clears the request and the FIFO
        @(negedge clk);
        {burst_sel, frame_beats, frame_start} = {2'h3, 24'd64, 1'b1};
        {sel_n, nxt, ea, left} = {32'd16, frame_base, frame_base, 32'd64};
        repeat (8) @(negedge clk);
        sys_rst_n = 1'b0;
        frame_start = 1'b0;
        @(negedge clk);
        check({arvalid, rready, busy, fifo_valid, fifo_level}, 10'h0);
        stop_test();
    end
endmodule // tb
